// ### core/stream_link_select.sv
// Link selector: picks data, control and presence of the addressed link.
// Assumes the link index is already folded into range.
`include "stream_read_params.svh"
module stream_link_select (
   stream_read_if.select ifc // Select side of the carrier
);
   logic [31:0] data_arr [`NUM_LINKS_MAX];

   // Unpack the flat data bus, one word per link
   genvar g;
   generate
      for (g = 0; g < `NUM_LINKS_MAX; g++)
      begin : g_unpack
         assign data_arr[g] = ifc.link_data_all[g*32 +: 32];
      end
   endgenerate

   // Selected link
   assign ifc.sel_data = data_arr[ifc.op.link];
   assign ifc.sel_ctrl = ifc.link_ctrl_all[ifc.op.link];
   assign ifc.sel_present = ifc.link_present_all[ifc.op.link];
endmodule // stream_link_select

// ### core/stream_op_decode.sv
// Instruction decoder for the static and dynamic stream read forms.
// Assumes the instruction and rB value are stable for the cycle.
`include "stream_read_params.svh"
module stream_op_decode #(
   parameter int LINK_COUNT = `DEF_LINK_COUNT,
   parameter int EXTENDED = `DEF_EXTENDED
) (
   stream_read_if.decode ifc // Decode side of the carrier
);
   logic dyn;
   logic sta;
   logic [3:0] idx;
   logic ext_ok;

   // Form detection; no reads exist without links
   assign sta = (ifc.instr[31:26] == `OPC_STATIC) && (LINK_COUNT > 0);
   assign dyn = (ifc.instr[31:26] == `OPC_DYNAMIC) && (LINK_COUNT > 0);
   assign ext_ok = (EXTENDED == 1);
   assign idx = dyn ? ifc.rb[3:0] : ifc.instr[3:0];

   // Field extraction; extended flags are dropped when not configured
   always_comb
   begin
      ifc.op.is_stream = sta | dyn;
      ifc.op.dest = ifc.instr[25:21];
      ifc.op.raw_link = ifc.instr[3:0];
      ifc.op.link = ({28'h0000000, idx} >= 32'(LINK_COUNT)) ? 4'h0 : idx;
      ifc.op.nonblock = dyn ? ifc.instr[`DYN_N_BIT] : ifc.instr[`STA_N_BIT];
      ifc.op.ctrl = dyn ? ifc.instr[`DYN_C_BIT] : ifc.instr[`STA_C_BIT];
      ifc.op.test = ext_ok & (dyn ? ifc.instr[`DYN_T_BIT] : ifc.instr[`STA_T_BIT]);
      ifc.op.atomic = ext_ok & (dyn ? ifc.instr[`DYN_A_BIT] : ifc.instr[`STA_A_BIT]);
      ifc.op.excp = ext_ok & (dyn ? ifc.instr[`DYN_E_BIT] : ifc.instr[`STA_E_BIT]);
   end
endmodule // stream_op_decode

// ### core/stream_read_port.sv
// Stream read port: carries out static and dynamic stream reads.
// Assumes producers run on REF_CLK and that an instruction is taken when
// ISSUE_VALID is high while STALL is low.
`include "stream_read_params.svh"
module stream_read_port #(
   parameter int LINK_COUNT = `DEF_LINK_COUNT,
   parameter int STREAM_EXC = `DEF_STREAM_EXC,
   parameter int EXTENDED = `DEF_EXTENDED,
   parameter int MMU = `DEF_MMU,
   parameter int PRIV_ALLOW = `DEF_PRIV_ALLOW,
   parameter int AREA_OPT = `DEF_AREA_OPT
) (
   input wire logic REF_CLK, // Processor clock
   input wire logic RESET, // Async reset, active high
   input wire logic ISSUE_VALID, // Instruction offered
   input wire logic [31:0] ISSUE_INSTR, // Instruction word
   input wire logic [31:0] ISSUE_RB, // Second source register value
   input wire logic ISSUE_DELAY_SLOT, // Instruction sits in a delay slot
   input wire logic USER_MODE, // User mode bit of machine status
   input wire logic IRQ_PENDING, // Interrupt waiting
   input wire logic STREAM_ERROR_CLR, // Clear the stream error flag
   input wire logic [511:0] LINK_DATA, // Link words, link n at [32n+31:32n]
   input wire logic [15:0] LINK_CONTROL, // Link control flags
   input wire logic [15:0] LINK_PRESENT, // Link data present
   output logic [15:0] LINK_READ, // One-cycle read strobes
   output logic STALL, // Pipeline held
   output logic WB_VALID, // Destination write pulse
   output logic [4:0] WB_REG, // Destination register number
   output logic [31:0] WB_DATA, // Destination value
   output logic CARRY, // Carry flag
   output logic STREAM_ERROR, // Sticky stream error flag
   output logic EXC_VALID, // Exception pulse
   output logic [4:0] EXC_CAUSE, // Exception cause field
   output logic [3:0] EXC_LINK, // Exception link field
   output logic [31:0] EXC_DATA, // Exception data register
   output logic IRQ_ACCEPT, // Stall abandoned for interrupt service
   output logic IRQ_BLOCK // Interrupts held off
);
   // ----------------------------------------------------------------
   // Sub-blocks
   // ----------------------------------------------------------------
   stream_read_if ifc ();

   stream_op_decode #(
      .LINK_COUNT(LINK_COUNT),
      .EXTENDED(EXTENDED)
   ) u_decode (
      .ifc(ifc)
   );

   stream_link_select u_select (
      .ifc(ifc)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   stream_read_pkg::state_t state_reg, state_next;
   logic [31:0] instr_reg, instr_next;
   logic [31:0] rb_reg, rb_next;
   logic delay_reg, delay_next;
   logic stall_reg, stall_next;
   logic wb_valid_reg, wb_valid_next;
   logic [4:0] wb_reg_reg, wb_reg_next;
   logic [31:0] wb_data_reg, wb_data_next;
   logic carry_reg, carry_next;
   logic serr_reg, serr_next;
   logic exc_valid_reg, exc_valid_next;
   logic [4:0] exc_cause_reg, exc_cause_next;
   logic [3:0] exc_link_reg, exc_link_next;
   logic [31:0] exc_data_reg, exc_data_next;
   logic irq_acc_reg, irq_acc_next;
   logic irq_block_reg, irq_block_next;
   logic [15:0] read_reg, read_next;
   logic idle;
   logic eval;
   logic delay_cur;
   logic priv_viol;
   logic mismatch;
   logic serr_set;
   logic may_serve;

   // The request under work comes from the issue port when idle, else from capture
   assign idle = (state_reg == stream_read_pkg::ST_IDLE);
   assign ifc.instr = idle ? ISSUE_INSTR : instr_reg;
   assign ifc.rb = idle ? ISSUE_RB : rb_reg;
   assign delay_cur = idle ? ISSUE_DELAY_SLOT : delay_reg;
   assign ifc.link_data_all = LINK_DATA;
   assign ifc.link_ctrl_all = LINK_CONTROL;
   // A word strobed last cycle is still shown by the producer; hide it so it
   // is never read twice. Costs one cycle on back-to-back reads of one link.
   assign ifc.link_present_all = LINK_PRESENT & ~read_reg;

   // Privileged check and control-bit check
   assign priv_viol = (MMU >= 1) && (PRIV_ALLOW != 1) && USER_MODE;
   assign mismatch = ifc.sel_present && (ifc.sel_ctrl != ifc.op.ctrl);
   assign may_serve = (EXTENDED == 1) && !ifc.op.atomic && !delay_cur;

   // Evaluate now when idle in the fast build, or in the hold and wait states
   assign eval = (idle && ISSUE_VALID && ifc.op.is_stream && (AREA_OPT == 0)) || !idle;

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      instr_next = instr_reg;
      rb_next = rb_reg;
      delay_next = delay_reg;
      wb_valid_next = 1'b0;
      wb_reg_next = wb_reg_reg;
      wb_data_next = wb_data_reg;
      carry_next = carry_reg;
      serr_set = 1'b0;
      exc_valid_next = 1'b0;
      exc_cause_next = exc_cause_reg;
      exc_link_next = exc_link_reg;
      exc_data_next = exc_data_reg;
      irq_acc_next = 1'b0;
      irq_block_next = irq_block_reg;
      read_next = 16'h0000;
      // Capture the request on issue so later cycles see a stable copy
      if (idle && ISSUE_VALID && ifc.op.is_stream)
      begin
         instr_next = ISSUE_INSTR;
         rb_next = ISSUE_RB;
         delay_next = ISSUE_DELAY_SLOT;
         if (AREA_OPT != 0)
         begin
            state_next = stream_read_pkg::ST_AREA;
            irq_block_next = 1'b1;
         end
      end
      if (eval)
      begin
         if (priv_viol)
         begin
            // Privileged fault: the link is left alone
            exc_valid_next = 1'b1;
            exc_cause_next = `CAUSE_PRIV;
            irq_block_next = ifc.op.atomic;
            state_next = stream_read_pkg::ST_IDLE;
         end
         else if (ifc.sel_present)
         begin
            serr_set = mismatch;
            if (!ifc.op.test)
            begin
               read_next[ifc.op.link] = 1'b1;
            end
            if (ifc.op.excp && mismatch && (STREAM_EXC == 1))
            begin
               exc_valid_next = 1'b1;
               exc_cause_next = `CAUSE_STREAM;
               exc_link_next = ifc.op.raw_link;
               exc_data_next = ifc.sel_data;
            end
            else
            begin
               wb_valid_next = 1'b1;
               wb_reg_next = ifc.op.dest;
               wb_data_next = ifc.sel_data;
               if (ifc.op.nonblock)
               begin
                  carry_next = 1'b0;
               end
            end
            irq_block_next = ifc.op.atomic;
            state_next = stream_read_pkg::ST_IDLE;
         end
         else if (ifc.op.nonblock)
         begin
            // Nothing there: destination gets whatever the link shows
            wb_valid_next = 1'b1;
            wb_reg_next = ifc.op.dest;
            wb_data_next = ifc.sel_data;
            carry_next = 1'b1;
            irq_block_next = ifc.op.atomic;
            state_next = stream_read_pkg::ST_IDLE;
         end
         else if (may_serve && IRQ_PENDING)
         begin
            // Give up the stall; the instruction is re-run after the handler
            irq_acc_next = 1'b1;
            irq_block_next = 1'b0;
            state_next = stream_read_pkg::ST_IDLE;
         end
         else
         begin
            state_next = stream_read_pkg::ST_WAIT;
            irq_block_next = !may_serve;
         end
      end
   end

   // Sticky error flag: a new mismatch beats a clear in the same cycle
   always_comb
   begin
      serr_next = serr_reg;
      if (STREAM_ERROR_CLR)
      begin
         serr_next = 1'b0;
      end
      if (serr_set)
      begin
         serr_next = 1'b1;
      end
   end

   // Stall output shows any non-idle next state
   assign stall_next = (state_next != stream_read_pkg::ST_IDLE);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state_reg <= stream_read_pkg::ST_IDLE;
         instr_reg <= 32'h00000000;
         rb_reg <= 32'h00000000;
         delay_reg <= 1'b0;
         stall_reg <= 1'b0;
         wb_valid_reg <= 1'b0;
         wb_reg_reg <= 5'h00;
         wb_data_reg <= 32'h00000000;
         carry_reg <= 1'b0;
         serr_reg <= 1'b0;
         exc_valid_reg <= 1'b0;
         exc_cause_reg <= 5'h00;
         exc_link_reg <= 4'h0;
         exc_data_reg <= 32'h00000000;
         irq_acc_reg <= 1'b0;
         irq_block_reg <= 1'b0;
         read_reg <= 16'h0000;
      end
      else
      begin
         state_reg <= state_next;
         instr_reg <= instr_next;
         rb_reg <= rb_next;
         delay_reg <= delay_next;
         stall_reg <= stall_next;
         wb_valid_reg <= wb_valid_next;
         wb_reg_reg <= wb_reg_next;
         wb_data_reg <= wb_data_next;
         carry_reg <= carry_next;
         serr_reg <= serr_next;
         exc_valid_reg <= exc_valid_next;
         exc_cause_reg <= exc_cause_next;
         exc_link_reg <= exc_link_next;
         exc_data_reg <= exc_data_next;
         irq_acc_reg <= irq_acc_next;
         irq_block_reg <= irq_block_next;
         read_reg <= read_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------------------------------
   assign LINK_READ = read_reg;
   assign STALL = stall_reg;
   assign WB_VALID = wb_valid_reg;
   assign WB_REG = wb_reg_reg;
   assign WB_DATA = wb_data_reg;
   assign CARRY = carry_reg;
   assign STREAM_ERROR = serr_reg;
   assign EXC_VALID = exc_valid_reg;
   assign EXC_CAUSE = exc_cause_reg;
   assign EXC_LINK = exc_link_reg;
   assign EXC_DATA = exc_data_reg;
   assign IRQ_ACCEPT = irq_acc_reg;
   assign IRQ_BLOCK = irq_block_reg;
endmodule // stream_read_port

// ### include/stream_read_if.sv
// Carrier between the sequencer, the decoder and the link selector.
// Assumes all three sit on the same clock.
interface stream_read_if;
   logic [31:0] instr;
   logic [31:0] rb;
   stream_read_pkg::op_t op;
   logic [511:0] link_data_all;
   logic [15:0] link_ctrl_all;
   logic [15:0] link_present_all;
   logic [31:0] sel_data;
   logic sel_ctrl;
   logic sel_present;

   modport decode (input instr, input rb, output op);
   modport select (input op, input link_data_all, input link_ctrl_all,
      input link_present_all, output sel_data, output sel_ctrl, output sel_present);
   modport core (output instr, output rb, input op, output link_data_all,
      output link_ctrl_all, output link_present_all, input sel_data,
      input sel_ctrl, input sel_present);
endinterface

// ### include/stream_read_params.svh
// Constants for the stream read port: opcodes, field positions, cause codes.
// Assumes a 32-bit instruction word whose bit 0 (MSB first numbering) is bit 31 here.
`ifndef STREAM_READ_PARAMS_SVH
`define STREAM_READ_PARAMS_SVH

// ----------------------------------------------------------------
// Opcodes (instruction bits 0..5)
// ----------------------------------------------------------------
`define OPC_STATIC 6'h1b
`define OPC_DYNAMIC 6'h13

// ----------------------------------------------------------------
// Flag positions, static form then dynamic form
// ----------------------------------------------------------------
`define STA_N_BIT 15
`define STA_C_BIT 14
`define STA_T_BIT 13
`define STA_A_BIT 12
`define STA_E_BIT 11
`define DYN_N_BIT 9
`define DYN_C_BIT 8
`define DYN_T_BIT 7
`define DYN_A_BIT 6
`define DYN_E_BIT 5

// ----------------------------------------------------------------
// Exception cause codes and configuration defaults
// ----------------------------------------------------------------
`define CAUSE_STREAM 5'h00
`define CAUSE_PRIV 5'h07
`define NUM_LINKS_MAX 16
`define DEF_LINK_COUNT 16
`define DEF_STREAM_EXC 1
`define DEF_EXTENDED 1
`define DEF_MMU 0
`define DEF_PRIV_ALLOW 0
`define DEF_AREA_OPT 0

`endif

// ### include/stream_read_pkg.sv
// Types shared by the stream read port modules.
// Assumes the constants header is compiled alongside.
package stream_read_pkg;

   // Decoded stream read request
   typedef struct packed {
      logic is_stream;
      logic [4:0] dest;
      logic [3:0] link;
      logic [3:0] raw_link;
      logic nonblock;
      logic ctrl;
      logic test;
      logic atomic;
      logic excp;
   } op_t;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_AREA = 3'b010,
      ST_WAIT = 3'b100
   } state_t;

endpackage

// ### test/stream_producer.sv
// Stream producer model: sixteen links holding one word each, loaded by the bench.
// Assumes the bench loads a link only while it is empty.
module stream_producer (
   input wire logic clk, // Processor clock
   input wire logic rst, // Async reset
   input wire logic [15:0] link_read, // Strobes from the port
   input wire logic load, // Offer a word
   input wire logic [3:0] load_link, // Link to load
   input wire logic [31:0] load_data, // Word
   input wire logic load_ctrl, // Control flag
   output logic [511:0] link_data, // Link words
   output logic [15:0] link_ctrl, // Control flags
   output logic [15:0] link_present // Word present
);
   // ----------------------------------------------------------------
   // Link state
   // ----------------------------------------------------------------
   // A consumed word turns to its inverse, so a stale read never passes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         link_data <= 512'h0;
         link_ctrl <= 16'h0;
         link_present <= 16'h0;
      end
      else
      begin
         for (int i = 0; i < 16; i++)
            if (link_read[i])
            begin
               link_present[i] <= 1'b0;
               link_data[32*i +: 32] <= ~link_data[32*i +: 32];
            end
         if (load)
         begin
            link_data[32*load_link +: 32] <= load_data;
            link_ctrl[load_link] <= load_ctrl;
            link_present[load_link] <= 1'b1;
         end
      end
   end
endmodule // stream_producer

// ### test/stream_read_checker.sv
// Concurrent checks on the stream read port, bound to its top module.
// Assumes a single clock domain and registered outputs.
module stream_read_checker (
   input wire logic REF_CLK, // Clock
   input wire logic RESET, // Async reset
   input wire logic ISSUE_VALID, // Instruction offered
   input wire logic STREAM_ERROR_CLR, // Error clear
   input wire logic IRQ_PENDING, // Interrupt waiting
   input wire logic [15:0] LINK_PRESENT, // Words present
   input wire logic [15:0] LINK_READ, // Read strobes
   input wire logic STALL, // Pipeline held
   input wire logic WB_VALID, // Write pulse
   input wire logic [31:0] WB_DATA, // Write value
   input wire logic CARRY, // Carry flag
   input wire logic STREAM_ERROR, // Error flag
   input wire logic EXC_VALID, // Exception pulse
   input wire logic [4:0] EXC_CAUSE, // Cause code
   input wire logic IRQ_ACCEPT, // Stall abandoned
   input wire logic IRQ_BLOCK // Interrupts held off
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);
   // A word is consumed once: no strobe twice running on one link
   property p_strobe_pulse;
      (LINK_READ != 16'h0) |=> ((LINK_READ & $past(LINK_READ)) == 16'h0);
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse)
      else $error("read strobe held");
   property p_strobe_present;
      (LINK_READ != 16'h0) |-> ((LINK_READ & ~$past(LINK_PRESENT)) == 16'h0);
   endproperty
   a_strobe_present: assert property (p_strobe_present)
      else $error("strobe on an empty link");
   property p_exc_keeps_wb;
      EXC_VALID |-> (!WB_VALID && $stable(WB_DATA));
   endproperty
   a_exc_keeps_wb: assert property (p_exc_keeps_wb)
      else $error("destination written on exception");
   property p_carry;
      $changed(CARRY) |-> WB_VALID;
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry changed without completion");
   property p_err_sticky;
      $fell(STREAM_ERROR) |-> $past(STREAM_ERROR_CLR);
   endproperty
   a_err_sticky: assert property (p_err_sticky)
      else $error("error flag dropped by itself");
   property p_stream_exc_err;
      (EXC_VALID && EXC_CAUSE == 5'h00) |-> STREAM_ERROR;
   endproperty
   a_stream_exc_err: assert property (p_stream_exc_err)
      else $error("stream exception without error flag");
   property p_stall_exit;
      $fell(STALL) |-> (WB_VALID || EXC_VALID || IRQ_ACCEPT);
   endproperty
   a_stall_exit: assert property (p_stall_exit)
      else $error("stall ended without an answer");
   // The fast build may give up a blocking read in its issue cycle, before any stall
   property p_irq_accept;
      IRQ_ACCEPT |-> ($past(IRQ_PENDING) && ($past(STALL) || $past(ISSUE_VALID))
         && !STALL && !IRQ_BLOCK);
   endproperty
   a_irq_accept: assert property (p_irq_accept)
      else $error("interrupt taken when not allowed");
endmodule // stream_read_checker
bind stream_read_port stream_read_checker chk (.REF_CLK, .RESET, .ISSUE_VALID, .STREAM_ERROR_CLR,
   .IRQ_PENDING, .LINK_PRESENT, .LINK_READ, .STALL, .WB_VALID, .WB_DATA, .CARRY,
   .STREAM_ERROR, .EXC_VALID, .EXC_CAUSE, .IRQ_ACCEPT, .IRQ_BLOCK);

// ### test/tb.sv
// Self-checking bench for the stream read port with a producer on its links.
// Assumes answers show right after the edge that takes an issue.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] FN = 5'h10, FC = 5'h08, FT = 5'h04, FA = 5'h02, FE = 5'h01;
   logic REF_CLK, RESET, ISSUE_VALID, ISSUE_DELAY_SLOT, USER_MODE, IRQ_PENDING;
   logic STREAM_ERROR_CLR, STALL, WB_VALID, CARRY, STREAM_ERROR, EXC_VALID;
   logic IRQ_ACCEPT, IRQ_BLOCK, ld, ld_c;
   logic [31:0] ISSUE_INSTR, ISSUE_RB, WB_DATA, EXC_DATA, ld_d;
   logic [511:0] LINK_DATA;
   logic [15:0] LINK_CONTROL, LINK_PRESENT, LINK_READ;
   logic [4:0] WB_REG, EXC_CAUSE;
   logic [3:0] EXC_LINK, ld_l;
   int fails, check_count;
   logic a_iv, a_st, a_wv, a_se, a_ev;
   logic [15:0] a_rd;
   logic [31:0] a_wd;
   // Four links, so higher indexes fall back to link zero
   stream_read_port #(.LINK_COUNT(4), .MMU(1)) dut (.REF_CLK, .RESET, .ISSUE_VALID,
      .ISSUE_INSTR, .ISSUE_RB, .ISSUE_DELAY_SLOT, .USER_MODE, .IRQ_PENDING,
      .STREAM_ERROR_CLR, .LINK_DATA, .LINK_CONTROL, .LINK_PRESENT, .LINK_READ, .STALL,
      .WB_VALID, .WB_REG, .WB_DATA, .CARRY, .STREAM_ERROR, .EXC_VALID, .EXC_CAUSE,
      .EXC_LINK, .EXC_DATA, .IRQ_ACCEPT, .IRQ_BLOCK);
   stream_producer prod (.clk(REF_CLK), .rst(RESET), .link_read(LINK_READ), .load(ld),
      .load_link(ld_l), .load_data(ld_d), .load_ctrl(ld_c), .link_data(LINK_DATA),
      .link_ctrl(LINK_CONTROL), .link_present(LINK_PRESENT));
   // Area build with stream exceptions off; its strobes reach no producer, so test reads only
   stream_read_port #(.LINK_COUNT(4), .STREAM_EXC(0), .AREA_OPT(1)) dut_area (.REF_CLK,
      .RESET, .ISSUE_VALID(a_iv), .ISSUE_INSTR, .ISSUE_RB, .ISSUE_DELAY_SLOT, .USER_MODE,
      .IRQ_PENDING, .STREAM_ERROR_CLR, .LINK_DATA, .LINK_CONTROL, .LINK_PRESENT,
      .LINK_READ(a_rd), .STALL(a_st), .WB_VALID(a_wv), .WB_REG(), .WB_DATA(a_wd), .CARRY(),
      .STREAM_ERROR(a_se), .EXC_VALID(a_ev), .EXC_CAUSE(), .EXC_LINK(), .EXC_DATA(),
      .IRQ_ACCEPT(), .IRQ_BLOCK());
   // Clock, 8 ns period
   initial
   begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Instruction word, flags {n,c,t,a,e}, destination register 3
   function automatic logic [31:0] gi(input logic dyn, input logic [4:0] fl,
      input logic [3:0] lk);
      if (dyn)
         return {6'h13, 5'h03, 10'h000, 1'b0, fl, 5'h00};
      return {6'h1b, 5'h03, 5'h00, fl, 7'h00, lk};
   endfunction
   task automatic put(input logic [3:0] l, input logic [31:0] d, input logic c);
      @(posedge REF_CLK);
      ld <= 1'b1;
      ld_l <= l;
      ld_d <= d;
      ld_c <= c;
      @(posedge REF_CLK);
      ld <= 1'b0;
   endtask
   task automatic issue(input logic [31:0] ins, input logic [31:0] r);
      @(posedge REF_CLK);
      ISSUE_INSTR <= ins;
      ISSUE_RB <= r;
      ISSUE_VALID <= 1'b1;
      @(posedge REF_CLK);
      ISSUE_VALID <= 1'b0;
      #1;
   endtask
   // Bounded wait: a stalled read answers within a few cycles of data
   task automatic wait_wb;
      for (int i = 0; i < 8 && WB_VALID !== 1'b1; i++)
      begin
         @(posedge REF_CLK);
         #1;
      end
   endtask
   task automatic clear_err;
      @(posedge REF_CLK);
      STREAM_ERROR_CLR <= 1'b1;
      @(posedge REF_CLK);
      STREAM_ERROR_CLR <= 1'b0;
      #1;
      chk(STREAM_ERROR, 1'b0);
   endtask
   task automatic t_basic;
      for (int c = 0; c < 2; c++)
      begin
         put(4'h2, 32'h5a5a_0000 + c, c[0]);
         issue(gi(1'b0, c[0] ? FC : 5'h00, 4'h2), 32'h0);
         chk({WB_VALID, WB_REG, LINK_READ}, {1'b1, 5'h03, 16'h0004});
         chk(WB_DATA, 32'h5a5a_0000 + c);
         chk(STREAM_ERROR, 1'b0);
      end
   endtask
   task automatic t_stall;
      issue(gi(1'b0, 5'h00, 4'h1), 32'h0);
      repeat (3) @(posedge REF_CLK);
      #1;
      chk({STALL, WB_VALID}, 2'b10);
      put(4'h1, 32'h0bad_f00d, 1'b0);
      wait_wb;
      chk({WB_VALID, STALL, WB_DATA}, {2'b10, 32'h0bad_f00d});
   endtask
   task automatic t_nonblk;
      issue(gi(1'b0, FN | FC, 4'h3), 32'h0);
      chk({WB_VALID, STALL, CARRY, STREAM_ERROR}, 4'b1010);
      put(4'h3, 32'h1111_2222, 1'b0);
      issue(gi(1'b0, FN, 4'h3), 32'h0);
      chk({CARRY, WB_DATA}, {1'b0, 32'h1111_2222});
   endtask
   task automatic t_mismatch;
      put(4'h3, 32'hcafe_0001, 1'b1);
      issue(gi(1'b0, FE, 4'h3), 32'h0);
      chk({EXC_VALID, WB_VALID, EXC_CAUSE, EXC_LINK}, {2'b10, 5'h00, 4'h3});
      chk(WB_DATA, 32'h1111_2222);
      chk(EXC_DATA, 32'hcafe_0001);
      chk(STREAM_ERROR, 1'b1);
      clear_err;
      put(4'h2, 32'h0000_0077, 1'b0);
      issue(gi(1'b0, FC, 4'h2), 32'h0);
      chk({WB_VALID, EXC_VALID, STREAM_ERROR}, 3'b101);
      clear_err;
   endtask
   task automatic t_test;
      put(4'h1, 32'h7e57_0001, 1'b0);
      issue(gi(1'b0, FT, 4'h1), 32'h0);
      chk({LINK_READ, WB_DATA}, {16'h0000, 32'h7e57_0001});
      issue(gi(1'b0, 5'h00, 4'h1), 32'h0);
      chk(LINK_READ, 16'h0002);
   endtask
   // Static index 9, dynamic 6 with junk above the low bits, dynamic 2
   task automatic t_range;
      logic [3:0] lk[3] = '{4'h0, 4'h0, 4'h2};
      logic [31:0] rv[3] = '{32'h0, 32'hffff_fff6, 32'h0000_0012};
      for (int i = 0; i < 3; i++)
      begin
         put(lk[i], 32'h0d00_0000 + i, 1'b0);
         issue(gi(i > 0, 5'h00, 4'h9), rv[i]);
         chk({LINK_READ, WB_DATA}, {16'h0001 << lk[i], 32'h0d00_0000 + i});
      end
   endtask
   task automatic t_priv;
      put(4'h2, 32'h0000_0099, 1'b0);
      USER_MODE <= 1'b1;
      issue(gi(1'b0, 5'h00, 4'h2), 32'h0);
      chk({EXC_VALID, EXC_CAUSE, LINK_READ}, {1'b1, 5'h07, 16'h0000});
      @(posedge REF_CLK);
      USER_MODE <= 1'b0;
      issue(gi(1'b0, 5'h00, 4'h2), 32'h0);
      chk(WB_DATA, 32'h0000_0099);
   endtask
   // Interrupt pending from issue: plain (given up before any stall), atomic, then in a delay slot
   task automatic t_irq;
      logic seen;
      for (int k = 0; k < 3; k++)
      begin
         @(posedge REF_CLK);
         IRQ_PENDING <= 1'b1;
         ISSUE_DELAY_SLOT <= (k == 2);
         issue(gi(1'b0, (k == 1) ? FA : 5'h00, 4'h1), 32'h0);
         seen = IRQ_ACCEPT;
         repeat (3)
         begin
            @(posedge REF_CLK);
            #1;
            seen |= IRQ_ACCEPT;
         end
         chk({seen, STALL, IRQ_BLOCK}, {k == 0, k != 0, k != 0});
         if (k > 0)
         begin
            put(4'h1, 32'h0000_0040 + k, 1'b0);
            wait_wb;
            chk(WB_DATA, 32'h0000_0040 + k);
         end
      end
      @(posedge REF_CLK);
      IRQ_PENDING <= 1'b0;
      ISSUE_DELAY_SLOT <= 1'b0;
   endtask
   // Refused opcode, then area build: two-cycle answer, e flag ignored, no strobe
   task automatic t_area;
      issue(32'h8000_0003, 32'h0);
      chk({WB_VALID, EXC_VALID, STALL, LINK_READ}, 19'h0);
      put(4'h1, 32'h0a0a_0001, 1'b1);
      ISSUE_INSTR <= gi(1'b0, FT | FE, 4'h1);
      a_iv <= 1'b1;
      @(posedge REF_CLK);
      a_iv <= 1'b0;
      #1;
      chk({a_wv, a_st}, 2'b01);
      @(posedge REF_CLK);
      #1;
      chk({a_wv, a_st, a_ev, a_se, a_rd}, {4'b1001, 16'h0000});
      chk(a_wd, 32'h0a0a_0001);
   endtask
   // Main sequence
   initial
   begin
      RESET = 1'b1;
      ISSUE_VALID = 1'b0;
      a_iv = 1'b0;
      ISSUE_INSTR = 32'h0;
      ISSUE_RB = 32'h0;
      ISSUE_DELAY_SLOT = 1'b0;
      USER_MODE = 1'b0;
      IRQ_PENDING = 1'b0;
      STREAM_ERROR_CLR = 1'b0;
      ld = 1'b0;
      ld_l = 4'h0;
      ld_d = 32'h0;
      ld_c = 1'b0;
      fails = 0;
      check_count = 0;
      repeat (20) @(posedge REF_CLK);
      RESET <= 1'b0;
      t_basic;
      t_stall;
      t_nonblk;
      t_mismatch;
      t_test;
      t_range;
      t_priv;
      t_irq;
      t_area;
      test_done;
   end
   // Watchdog: the sequence needs a few hundred cycles at most
   initial
   begin
      repeat (5000) @(posedge REF_CLK);
      fails++;
      test_done;
   end
endmodule // tb
